// ---- src/alu_core_pkg.sv ----
// Purpose: shared constants of the 8-bit core execution datapath
// Assumes: one reference clock, four clocks per instruction cycle
// Notes:   opcode fields follow the 14-bit instruction layout
package alu_core_pkg;
	localparam int INSN_W       = 14;
	localparam int DATA_W       = 8;
	localparam int PC_W         = 13;
	localparam int PROG_WORDS   = 4096;
	localparam int RAM_BYTES    = 192;
	localparam int STACK_DEPTH  = 8;
	// timing: one instruction cycle in reference clocks
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSN_CYCLE_NS = 200;
	localparam int CLKS_PER_INSN = (INSN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] Q_LAST = 2'(CLKS_PER_INSN - 1);
	// data memory map, low seven address bits
	localparam logic [6:0] ADDR_INDF   = 7'h00;
	localparam logic [6:0] ADDR_PCL    = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_FSR    = 7'h04;
	localparam logic [6:0] ADDR_PCLATH = 7'h0a;
	localparam logic [6:0] RAM_BASE    = 7'h20;
	localparam logic [7:0] BANK_SPAN   = 8'h60;
	// status field positions and reset values
	localparam int ST_C   = 0;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_Z   = 2;
	localparam int ST_RP0 = 5;
	localparam logic [7:0]  STATUS_RST = 8'h18;
	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	// instruction classes
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT  = 2'h1;
	localparam logic [1:0] CLS_CTRL = 2'h2;
	localparam logic [1:0] CLS_LIT  = 2'h3;
	localparam logic [13:0] INS_RETURN = 14'h0008;
	// byte-oriented operations
	localparam logic [3:0] OP_MOVWF = 4'h0;
	localparam logic [3:0] OP_CLR   = 4'h1;
	localparam logic [3:0] OP_SUBWF = 4'h2;
	localparam logic [3:0] OP_DECF  = 4'h3;
	localparam logic [3:0] OP_IORWF = 4'h4;
	localparam logic [3:0] OP_ANDWF = 4'h5;
	localparam logic [3:0] OP_XORWF = 4'h6;
	localparam logic [3:0] OP_ADDWF = 4'h7;
	localparam logic [3:0] OP_MOVF  = 4'h8;
	localparam logic [3:0] OP_COMF  = 4'h9;
	localparam logic [3:0] OP_INCF  = 4'ha;
	localparam logic [3:0] OP_DECSZ = 4'hb;
	localparam logic [3:0] OP_RRF   = 4'hc;
	localparam logic [3:0] OP_RLF   = 4'hd;
	localparam logic [3:0] OP_SWAPF = 4'he;
	localparam logic [3:0] OP_INCSZ = 4'hf;
endpackage

// ---- src/alu_core_datapath.sv ----
// Purpose: fetch/execute datapath with 8-bit ALU, working register and data memory
// Assumes: program memory answers i_prog_data for o_prog_addr within one instruction cycle
// Notes:   four reference clocks make one instruction cycle; state commits on the last
// Summary of operation
// - one whole 14-bit word fetched on the program bus each instruction cycle.
// - program bus and data memory are separate, fetch and data access overlap.
// - next instruction is fetched while the current one executes.
// - one cycle per instruction, 200 ns; branches flush and refill.
// - 8-bit ALU does add, subtract, shifts and logic.
// - arithmetic treats operands and results as two's complement.
// - two-operand forms use working register with file register or literal.
// - single-operand forms use working register or one file register.
// - working register is 8 bits and has no data memory address.
// - carry, digit carry and zero updated per instruction, else held.
// - in subtraction carry and digit carry mean no borrow.
// - special registers, program counter included, live in data memory.
// - file registers reachable directly and indirectly by any operation.
// - 4K program words of 14 bits, 192 data bytes.
`timescale 1ns/1ps
`default_nettype none
module alu_core_datapath
	import alu_core_pkg::*;
#(
	parameter int STACK_N = alu_core_pkg::STACK_DEPTH
)
(
	// clock and reset
	input  wire logic                           i_ref_clk,
	input  wire logic                           i_rstn,
	// program bus
	output logic [alu_core_pkg::PC_W-1:0]       o_prog_addr,
	input  wire logic [alu_core_pkg::INSN_W-1:0] i_prog_data,
	// observation
	output logic [alu_core_pkg::DATA_W-1:0]     o_work,
	output logic [alu_core_pkg::DATA_W-1:0]     o_status,
	output logic                                o_cycle_end
);
	import alu_core_pkg::*;

	logic [1:0]        q_q;
	logic [PC_W-1:0]   pc_q;
	logic [INSN_W-1:0] ir_q;
	logic              valid_q;
	logic [7:0]        w_q;
	logic [7:0]        status_q;
	logic [7:0]        status_d;
	logic [7:0]        fsr_q;
	logic [4:0]        pclath_q;
	logic [7:0]        ram_q [RAM_BYTES];
	logic [PC_W-1:0]   stack_q [STACK_N];
	logic [2:0]        sp_q;
	logic              commit;
	logic [7:0]        fa;
	logic [7:0]        fv;
	logic [6:0]        ram_off;
	logic [7:0]        ram_idx;
	logic              is_ram;
	logic [7:0]        opnd;
	logic [8:0]        add_s;
	logic [8:0]        sub_s;
	logic [4:0]        add_h;
	logic [4:0]        sub_h;
	logic [7:0]        res;
	logic              c_n;
	logic              digit_n;
	logic              wr_w;
	logic              wr_f;
	logic              up_c;
	logic              up_digit;
	logic              up_z;
	logic              is_sub;
	logic              is_add;
	logic              skip;
	logic              jump;
	logic              push;
	logic              pop;
	logic [PC_W-1:0]   tgt;

	// instruction cycle phase, advanced every clock; every other state change happens on the last phase
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			q_q <= 2'h0;
		else
			q_q <= (q_q == Q_LAST) ? 2'h0 : q_q + 2'h1;
	end
	assign commit      = (q_q == Q_LAST);
	assign o_cycle_end = commit;

	// file address: direct from instruction, or indirect through the pointer
	assign fa      = (ir_q[6:0] == ADDR_INDF) ? fsr_q : {status_q[ST_RP0], ir_q[6:0]};
	assign ram_off = fa[6:0] - RAM_BASE;
	assign ram_idx = fa[7] ? {1'b0, ram_off} + BANK_SPAN : {1'b0, ram_off};
	assign is_ram  = (fa[6:0] >= RAM_BASE);

	// file read; special registers mirror in both banks, unmapped reads zero
	always_comb
	begin
		fv = 8'h00;
		if (is_ram)
			fv = ram_q[ram_idx];
		else
			case (fa[6:0])
				ADDR_PCL:    fv = pc_q[7:0];
				ADDR_STATUS: fv = status_q;
				ADDR_FSR:    fv = fsr_q;
				ADDR_PCLATH: fv = {3'h0, pclath_q};
				default:     fv = 8'h00;
			endcase
	end

	// second operand is a literal or a file register; subtraction is operand minus w
	assign opnd  = (ir_q[13:12] == CLS_LIT) ? ir_q[7:0] : fv;
	assign add_s = {1'b0, opnd} + {1'b0, w_q};
	assign sub_s = {1'b0, opnd} + {1'b0, ~w_q} + 9'h001;
	assign add_h = {1'b0, opnd[3:0]} + {1'b0, w_q[3:0]};
	assign sub_h = {1'b0, opnd[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;

	// decode and ALU
	always_comb
	begin
		res    = fv;
		c_n      = status_q[ST_C];
		digit_n  = status_q[ST_DIGIT_CARRY];
		wr_w     = 1'b0;
		wr_f     = 1'b0;
		up_c     = 1'b0;
		up_digit = 1'b0;
		up_z   = 1'b0;
		is_sub = 1'b0;
		is_add = 1'b0;
		skip   = 1'b0;
		jump   = 1'b0;
		push   = 1'b0;
		pop    = 1'b0;
		tgt    = pc_q;
		if (valid_q)
			case (ir_q[13:12])
				CLS_BYTE:
				begin
					wr_w = !ir_q[7];
					wr_f = ir_q[7];
					up_z = 1'b1;
					case (ir_q[11:8])
						OP_MOVWF:
						begin
							up_z = 1'b0;
							res  = w_q;
							wr_w = 1'b0;
							if (ir_q == INS_RETURN)
							begin
								pop  = 1'b1;
								jump = 1'b1;
								tgt  = stack_q[sp_q - 3'h1];
							end
						end
						OP_CLR:   res = 8'h00;
						OP_SUBWF:
						begin
							is_sub = 1'b1;
							res    = sub_s[7:0];
						end
						OP_ADDWF:
						begin
							is_add = 1'b1;
							res    = add_s[7:0];
						end
						OP_DECF:  res = fv - 8'h01;
						OP_INCF:  res = fv + 8'h01;
						OP_IORWF: res = fv | w_q;
						OP_ANDWF: res = fv & w_q;
						OP_XORWF: res = fv ^ w_q;
						OP_MOVF:  res = fv;
						OP_COMF:  res = ~fv;
						OP_DECSZ:
						begin
							up_z = 1'b0;
							res  = fv - 8'h01;
							skip = (res == 8'h00);
						end
						OP_INCSZ:
						begin
							up_z = 1'b0;
							res  = fv + 8'h01;
							skip = (res == 8'h00);
						end
						OP_RRF:
						begin
							up_z = 1'b0;
							up_c = 1'b1;
							res  = {status_q[ST_C], fv[7:1]};
							c_n  = fv[0];
						end
						OP_RLF:
						begin
							up_z = 1'b0;
							up_c = 1'b1;
							res  = {fv[6:0], status_q[ST_C]};
							c_n  = fv[7];
						end
						OP_SWAPF:
						begin
							up_z = 1'b0;
							res  = {fv[3:0], fv[7:4]};
						end
						default: res = fv;
					endcase
				end
				CLS_BIT:
				begin
					// set, clear or test one bit of a file register
					case (ir_q[11:10])
						2'h0:
						begin
							wr_f = 1'b1;
							res  = fv & ~(8'h01 << ir_q[9:7]);
						end
						2'h1:
						begin
							wr_f = 1'b1;
							res  = fv | (8'h01 << ir_q[9:7]);
						end
						2'h2:    skip = !fv[ir_q[9:7]];
						default: skip = fv[ir_q[9:7]];
					endcase
				end
				CLS_CTRL:
				begin
					jump = 1'b1;
					push = !ir_q[11];
					tgt  = {pclath_q[4:3], ir_q[10:0]};
				end
				default:
				begin
					wr_w = 1'b1;
					casez (ir_q[11:8])
						4'b00??: res = ir_q[7:0];
						4'b01??:
						begin
							res  = ir_q[7:0];
							pop  = 1'b1;
							jump = 1'b1;
							tgt  = stack_q[sp_q - 3'h1];
						end
						4'b1000:
						begin
							res  = ir_q[7:0] | w_q;
							up_z = 1'b1;
						end
						4'b1001:
						begin
							res  = ir_q[7:0] & w_q;
							up_z = 1'b1;
						end
						4'b1010:
						begin
							res  = ir_q[7:0] ^ w_q;
							up_z = 1'b1;
						end
						4'b110?:
						begin
							is_sub = 1'b1;
							up_z   = 1'b1;
							res    = sub_s[7:0];
						end
						default:
						begin
							is_add = 1'b1;
							up_z   = 1'b1;
							res    = add_s[7:0];
						end
					endcase
				end
			endcase
		// arithmetic flag sources; borrow sense falls out of the inverted add
		if (is_add)
		begin
			up_c     = 1'b1;
			up_digit = 1'b1;
			c_n      = add_s[8];
			digit_n  = add_h[4];
		end
		if (is_sub)
		begin
			up_c     = 1'b1;
			up_digit = 1'b1;
			c_n      = sub_s[8];
			digit_n  = sub_h[4];
		end
		// a write to the low program counter byte is a computed branch
		if (wr_f && !is_ram && fa[6:0] == ADDR_PCL)
		begin
			jump = 1'b1;
			tgt  = {pclath_q, res};
		end
	end

	// status next value: software write first, then ALU flags override it
	always_comb
	begin
		status_d = status_q;
		if (wr_f && !is_ram && fa[6:0] == ADDR_STATUS)
			status_d = {res[7:5], status_q[4:3], res[2:0]};
		if (up_c)
			status_d[ST_C] = c_n;
		if (up_digit)
			status_d[ST_DIGIT_CARRY] = digit_n;
		if (up_z)
			status_d[ST_Z] = (res == 8'h00);
	end

	// fetch path: the word on the bus becomes the next instruction, flushed if this one branches or skips
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pc_q    <= RESET_VEC;
			ir_q    <= 14'h0000;
			valid_q <= 1'b0;
		end
		else if (commit)
		begin
			ir_q    <= i_prog_data;
			valid_q <= !(jump || skip);
			pc_q    <= jump ? tgt : pc_q + 13'h0001;
		end
	end
	assign o_prog_addr = pc_q;

	// working register; only the ALU writes it, it has no file address
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			w_q <= 8'h00;
		else if (commit && wr_w)
			w_q <= res;
	end
	assign o_work = w_q;

	// special registers
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			status_q <= STATUS_RST;
			fsr_q    <= 8'h00;
			pclath_q <= 5'h00;
		end
		else if (commit)
		begin
			status_q <= status_d;
			if (wr_f && !is_ram && fa[6:0] == ADDR_FSR)
				fsr_q <= res;
			if (wr_f && !is_ram && fa[6:0] == ADDR_PCLATH)
				pclath_q <= res[4:0];
		end
	end
	assign o_status = status_q;

	// general purpose data memory; no reset, contents undefined at power-up
	always_ff @(posedge i_ref_clk)
	begin
		if (commit && wr_f && is_ram)
			ram_q[ram_idx] <= res;
	end

	// return stack; wraps silently on overflow like the hardware it models
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			sp_q <= 3'h0;
		else if (commit && push)
			sp_q <= sp_q + 3'h1;
		else if (commit && pop)
			sp_q <= sp_q - 3'h1;
	end
	always_ff @(posedge i_ref_clk)
	begin
		if (commit && push)
			stack_q[sp_q] <= pc_q;
	end

	property p_fetch_latch;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		commit |=> ir_q == $past(i_prog_data);
	endproperty
	a_fetch_latch: assert property (p_fetch_latch) else $error("fetched word not latched");

	property p_cycle_len;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		commit |=> !commit [*3] ##1 commit;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("instruction cycle not four clocks");

	property p_pc_step;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && !jump) |=> pc_q == $past(pc_q) + 13'h0001;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("program counter did not step");

	property p_flush;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && jump) |=> !valid_q && pc_q == $past(tgt);
	endproperty
	a_flush: assert property (p_flush) else $error("branch did not flush");

	property p_work_hold;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		!(commit && wr_w) |=> $stable(w_q);
	endproperty
	a_work_hold: assert property (p_work_hold) else $error("working register changed without ALU write");

	property p_zero;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && up_z) |=> status_q[ST_Z] == ($past(res) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_flag_keep;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && !up_c && !(wr_f && !is_ram && fa[6:0] == ADDR_STATUS)) |=> $stable(status_q[ST_C]);
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("carry changed by unaffecting instruction");

	property p_borrow;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && is_sub) |=> status_q[ST_C] == ($past(opnd) >= $past(w_q)) ##3 commit;
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow sense wrong");

	property p_digit;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(commit && is_add) |=> status_q[ST_DIGIT_CARRY] == (({1'b0, $past(opnd[3:0])} + {1'b0, $past(w_q[3:0])}) > 5'h0f);
	endproperty
	a_digit: assert property (p_digit) else $error("digit carry wrong");
endmodule
`default_nettype wire

// ---- testbench/prog_mem_model.sv ----
// Purpose: behavioural program memory that answers the core's program bus
// Assumes: the bench loads words through load_word while the core is held in reset
// Notes:   unloaded words read as zero, which the core executes as a no-operation
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
	import alu_core_pkg::*;
(
	// program bus, address in and word out
	input  wire logic [alu_core_pkg::PC_W-1:0]   i_addr,
	output logic      [alu_core_pkg::INSN_W-1:0] o_data
);
	import alu_core_pkg::*;

	// whole 14-bit words, 4K deep; the memory sits on its own bus beside data memory
	logic [INSN_W-1:0] words [PROG_WORDS];

	// cleared at time zero so that stray fetches see a no-operation, not an unknown
	initial
	begin
		for (int k = 0; k < PROG_WORDS; k++)
			words[k] = '0;
	end

	// bench-side loader, called before reset is released
	task automatic load_word(input int addr, input logic [INSN_W-1:0] word);
		words[addr] = word;
	endtask

	// asynchronous read; bit 12 of the counter aliases, only 4K words exist
	assign o_data = words[i_addr[11:0]];
endmodule
`default_nettype wire

// ---- testbench/core_alu_execution_datapath_tb.sv ----
// Purpose: self-checking bench for the core fetch/execute datapath
// Assumes: 20 MHz reference clock, four clocks per instruction cycle
// Notes:   two programs walk every instruction class; expectations come from the tables below
`timescale 1ns/1ps
`default_nettype none
module core_alu_execution_datapath_tb;
	import alu_core_pkg::*;

	localparam int DRV   = 1;
	localparam int STEPS = 29;

	logic                 ref_clk;
	logic                 rstn;
	logic [PC_W-1:0]      prog_addr;
	logic [INSN_W-1:0]    prog_data;
	logic [DATA_W-1:0]    work;
	logic [DATA_W-1:0]    status;
	logic                 cycle_end;
	int                   errors;
	int                   samples_checked;

	// program: literals, byte ops on ram 20, indirect access, status read, goto with a flushed slot
	logic [13:0] prog_words [STEPS] = '{14'h300f, 14'h3e01, 14'h3ef0, 14'h3005, 14'h3c03, 14'h3cff,
		14'h00a0, 14'h0720, 14'h07a0, 14'h0820, 14'h0c20, 14'h0d20, 14'h3a07, 14'h38a0, 14'h390f,
		14'h0920, 14'h0e20, 14'h03a0, 14'h3020, 14'h0084, 14'h0a00, 14'h0803, 14'h2819, 14'h30ee,
		14'h30dd, 14'h3055, 14'h0100, 14'h281b, 14'h30ee};
	// expected state after commit edge j
	logic [7:0] exp_w [STEPS] = '{8'h00, 8'h0f, 8'h10, 8'h00, 8'h05, 8'hfe, 8'h01, 8'h01, 8'h02,
		8'h02, 8'h03, 8'h01, 8'h07, 8'h00, 8'ha0, 8'h00, 8'hfc, 8'h30, 8'h30, 8'h20, 8'h20, 8'h03,
		8'h18, 8'h18, 8'h18, 8'h55, 8'h00, 8'h00, 8'h00};
	// zero, digit carry, carry
	logic [2:0] exp_f [STEPS] = '{3'h0, 3'h0, 3'h2, 3'h5, 3'h5, 3'h0, 3'h3, 3'h3, 3'h0, 3'h0,
		3'h0, 3'h1, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0, 3'h4, 3'h4, 3'h4};

	// second program: skips, call and return, bank select, status and pcl written as files
	localparam int P2_WORDS = 32;
	localparam int P2_STEPS = 36;
	logic [13:0] prog2_words [P2_WORDS] = '{14'h3003, 14'h00a1, 14'h0ba1, 14'h0ba1, 14'h0ba1, 14'h30ee, 14'h1821,
		14'h30ee, 14'h1421, 14'h1c21, 14'h30ee, 14'h0fa1, 14'h201c, 14'h3a55, 14'h0221, 14'h0521, 14'h30c3,
		14'h1683, 14'h00a1, 14'h1283, 14'h0821, 14'h3007, 14'h0083, 14'h301a, 14'h0082, 14'h30ee, 14'h201e,
		14'h281b, 14'h3477, 14'h30ee, 14'h0a21, 14'h0008};
	// expected program counter, working register and whole status after commit edge j
	logic [7:0] exp2_pc [P2_STEPS] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
		8'h0b, 8'h0c, 8'h0d, 8'h1c, 8'h1d, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
		8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1e, 8'h1f, 8'h20, 8'h1b, 8'h1c, 8'h1b};
	logic [7:0] exp2_w [P2_STEPS] = '{8'h00, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
		8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h77, 8'h77, 8'h22, 8'he0, 8'h00, 8'hc3, 8'hc3, 8'hc3, 8'hc3,
		8'h02, 8'h07, 8'h07, 8'h1a, 8'h1a, 8'h1a, 8'h1a, 8'h1a, 8'h03, 8'h03, 8'h03, 8'h03};
	logic [7:0] exp2_st [P2_STEPS] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18,
		8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h1a, 8'h1e, 8'h1e, 8'h3e, 8'h3e, 8'h1e,
		8'h1a, 8'h1a, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1b, 8'h1b, 8'h1b, 8'h1b};

	alu_core_datapath i_alu_core_datapath (
		.i_ref_clk   (ref_clk),
		.i_rstn      (rstn),
		.o_prog_addr (prog_addr),
		.i_prog_data (prog_data),
		.o_work      (work),
		.o_status    (status),
		.o_cycle_end (cycle_end)
	);

	prog_mem_model i_prog_mem_model (
		.i_addr (prog_addr),
		.o_data (prog_data)
	);

	// reference clock
	initial
	begin
		ref_clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, expected, seen);
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// waits for the commit edge, returns the clocks spent; bounded so a dead phase counter cannot hang
	task automatic next_commit(output int clks);
		clks = 0;
		do
		begin
			@(negedge ref_clk);
			clks++;
		end
		while (cycle_end !== 1'b1 && clks < 16);
		@(posedge ref_clk);
		#DRV;
	endtask

	function automatic logic [12:0] exp_pc(input int j);
		if (j <= 22)
			return 13'(j + 1);
		return (j == 27) ? 13'h001b : 13'(j + 2 - ((j == 28) ? 2 : 0));
	endfunction

	// reset values on every output while reset is low
	task automatic test_reset_state();
		check("reset prog_addr", 16'(prog_addr), 16'h0000);
		check("reset work", 16'(work), 16'h0000);
		check("reset status", 16'(status), 16'(STATUS_RST));
		check("reset cycle_end", 16'(cycle_end), 16'h0000);
	endtask

	// release reset and walk the program one commit at a time
	task automatic test_program_run();
		int clks;
		@(posedge ref_clk);
		#DRV;
		rstn = 1'b1;
		for (int j = 0; j < STEPS; j++)
		begin
			next_commit(clks);
			check("clocks per instruction", 16'(clks), 16'(CLKS_PER_INSN));
			check("prog_addr", 16'(prog_addr), 16'(exp_pc(j)));
			check("work", 16'(work), 16'(exp_w[j]));
			check("status", 16'(status), 16'(STATUS_RST | {5'h00, exp_f[j]}));
		end
	endtask

	// reset dropped in mid-cycle must restore outputs and restart the program from word 0
	task automatic test_midrun_reset();
		repeat (2) @(posedge ref_clk);
		#DRV;
		rstn = 1'b0;
		@(posedge ref_clk);
		#DRV;
		test_reset_state();
		test_program_run();
	endtask

	// second program under a fresh reset; skipped and branched-over slots must act as no-operations
	task automatic test_control_run();
		int clks;
		rstn = 1'b0;
		for (int k = 0; k < P2_WORDS; k++)
			i_prog_mem_model.load_word(k, prog2_words[k]);
		repeat (2) @(posedge ref_clk);
		#DRV;
		rstn = 1'b1;
		for (int j = 0; j < P2_STEPS; j++)
		begin
			next_commit(clks);
			check("clocks per instruction", 16'(clks), 16'(CLKS_PER_INSN));
			check("prog_addr", 16'(prog_addr), 16'(exp2_pc[j]));
			check("work", 16'(work), 16'(exp2_w[j]));
			check("status", 16'(status), 16'(exp2_st[j]));
		end
	endtask

	// main sequence
	initial
	begin
		errors = 0;
		samples_checked = 0;
		rstn = 1'b0;
		@(posedge ref_clk);
		for (int k = 0; k < STEPS; k++)
			i_prog_mem_model.load_word(k, prog_words[k]);
		repeat (8) @(posedge ref_clk);
		#DRV;
		test_reset_state();
		test_program_run();
		test_midrun_reset();
		test_control_run();
		finish_test();
	end

	// watchdog: three program runs take under 500 clocks, so 1000 means a hang
	initial
	begin
		#(1000 * CLK_PERIOD_NS);
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
